/* File: pkg/cpualu_pkg.sv */
// Package for the core ALU: operation codes, widths, flag positions.
// Assumes a single core clock; operand routing done by the decoder.
package cpualu_pkg;

    localparam int WORD_W   = 16;
    localparam int BYTE_W   = 8;
    localparam int MUL_W    = 17;
    localparam int LIT_W    = 5;
    localparam int SHAMT_W  = 4;
    localparam int DIV_STEPS = 16;

    // Flag positions within the flag vector presented by the block
    localparam int FLG_CARRY = 0;
    localparam int FLG_ZERO  = 1;
    localparam int FLG_NEG   = 2;
    localparam int FLG_OVF   = 3;
    localparam int FLG_DIGIT = 4;
    localparam int FLG_W     = 5;
    localparam logic [4:0] FLAGS_RESET = 5'h00;

    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
        OP_ARITH_RIGHT_SHIFT, OP_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
        OP_MUL, OP_DIV, OP_NOP
    } cpualu_op_e;

    // Multiply modes
    typedef enum logic [2:0] {
        MUL_SS, MUL_UU, MUL_SLIT, MUL_ULIT, MUL_US, MUL_BB
    } cpualu_mul_e;

    // Destination select
    localparam logic DST_WREG = 1'b0;
    localparam logic DST_MEM  = 1'b1;

endpackage

/* File: src/cpualu_div.sv */
// Iterative restoring divider: 32/16 or 16/16, signed or unsigned.
// Assumes start only while idle; results appear with done pulse.
`timescale 1ns/1ps
module cpualu_div #(
    parameter int STEPS = cpualu_pkg::DIV_STEPS
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Request
    input  wire logic        start,
    input  wire logic        is_signed,
    input  wire logic        is_long,
    input  wire logic [31:0] dividend,
    input  wire logic [15:0] divisor,
    // Answer
    output logic             busy,
    output logic             done,
    output logic [15:0]      quot,
    output logic [15:0]      rem
);
    initial
    begin
        if (STEPS != cpualu_pkg::WORD_W)
            $error("divider steps must equal word width");
    end

    logic [31:0] rq_q,  rq_d;
    logic [16:0] acc_q, acc_d;
    logic [15:0] dvs_q;
    logic [4:0]  cnt_q;
    logic        nq_q, nr_q, busy_q, done_q;
    logic [15:0] quot_q, rem_q;

    // Sign handling: divide magnitudes, fix signs at the end
    wire [31:0] dvd_ext = is_long ? dividend
                        : (is_signed ? {{16{dividend[15]}}, dividend[15:0]}
                                     : {16'h0000, dividend[15:0]});
    wire        dvd_neg = is_signed & dvd_ext[31];
    wire        dvs_neg = is_signed & divisor[15];
    wire [31:0] dvd_mag = dvd_neg ? 32'h00000000 - dvd_ext : dvd_ext;
    wire [15:0] dvs_mag = dvs_neg ? 16'h0000 - divisor : divisor;

    // Long dividend: upper half preloads accumulator, one step per divisor bit
    wire [16:0] trial = {acc_q[15:0], rq_q[15]} - {1'b0, dvs_q};
    wire        take  = ~trial[16];
    wire [16:0] acc_nx = take ? trial : {acc_q[15:0], rq_q[15]};
    wire [15:0] q_fin = {rq_q[14:0], take};
    wire [15:0] r_fin = acc_nx[15:0];
    wire        last  = (cnt_q == 5'(STEPS - 1));

    assign acc_d = acc_nx;
    assign rq_d  = {rq_q[31:16], rq_q[14:0], take};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rq_q <= 32'h00000000; acc_q <= 17'h00000; dvs_q <= 16'h0000;
            cnt_q <= 5'h00; nq_q <= 1'b0; nr_q <= 1'b0;
            busy_q <= 1'b0; done_q <= 1'b0;
            quot_q <= 16'h0000; rem_q <= 16'h0000;
        end
        else if (start && !busy_q)
        begin
            rq_q  <= {16'h0000, dvd_mag[15:0]};
            acc_q <= {1'b0, dvd_mag[31:16]};
            dvs_q <= dvs_mag;
            nq_q  <= dvd_neg ^ dvs_neg;
            nr_q  <= dvd_neg;
            cnt_q <= 5'h00;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end
        else if (busy_q)
        begin
            acc_q <= acc_d;
            rq_q  <= rq_d;
            cnt_q <= cnt_q + 5'h01;
            if (last)
            begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
                quot_q <= nq_q ? 16'h0000 - q_fin : q_fin;
                rem_q  <= nr_q ? 16'h0000 - r_fin : r_fin;
            end
        end
        else
            done_q <= 1'b0;
    end

    assign busy = busy_q;
    assign done = done_q;
    assign quot = quot_q;
    assign rem  = rem_q;

    ////////////////////////////////////////////////////////////////////
    // Busy run counted here: a sixteen-deep repetition is too costly
    logic [4:0]  busy_run_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            busy_run_q <= 5'h00;
        else if (busy_q)
            busy_run_q <= busy_run_q + 5'h01;
        else
            busy_run_q <= 5'h00;
    end

    chk_div_length: assert property (@(posedge clk) disable iff (rst)
        start && !busy |=> busy ##15 busy ##1 (done && !busy))
        else $error("divide did not finish in sixteen steps");
    chk_div_count: assert property (@(posedge clk) disable iff (rst)
        done |-> busy_run_q == 5'(STEPS))
        else $error("divide busy run not one cycle per bit");
    chk_div_hold: assert property (@(posedge clk) disable iff (rst)
        busy |-> $stable(quot) && $stable(rem))
        else $error("divide results moved mid operation");
endmodule

/* File: src/cpualu_top.sv */
// ALU of the 16-bit core: add/sub/logic, shifts, multiplier, divider.
// Assumes the decoder supplies operands and routes results; one clock.
// Behaviour
// - 16-bit add, subtract, shift and logic
// - arithmetic uses two's complement values
// - add/subtract update carry, zero, negative, overflow, digit; shifts carry, zero, negative; logic zero, negative
// - subtraction carry flags mean not-borrow
// - byte or word width per instruction
// - operands and results by register or memory
// - 17x17 multiplier for mixed signedness
// - six multiply modes incl. literal, byte
// - 32/16 and 16/16 division, signed, unsigned
// - quotient and remainder to result registers
// - divisor any register, dividend aligned pair
// - one cycle per divisor bit
// - single-cycle shifts up to fifteen bits
// - multi-bit shifts register direct only
// - arithmetic right, left, logical right shifts
`timescale 1ns/1ps
module cpualu_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Operation request
    input  wire logic        op_valid,
    input  wire logic [3:0]  op_code,
    input  wire logic [2:0]  mul_mode,
    input  wire logic        byte_mode,
    input  wire logic        div_signed,
    input  wire logic        div_long,
    input  wire logic        src_is_mem,
    input  wire logic        dst_is_mem,
    input  wire logic        carry_in,
    // Operands
    input  wire logic [15:0] op_a,
    input  wire logic [15:0] op_b,
    input  wire logic [15:0] op_a_hi,
    input  wire logic [4:0]  literal,
    input  wire logic [3:0]  shift_amt,
    // Result
    output logic             res_valid,
    output logic [31:0]      res_data,
    output logic             res_to_mem,
    output logic             busy,
    output logic             op_refused,
    // Status and divide results
    output logic [4:0]       status_flags,
    output logic [15:0]      quotient_result_reg,
    output logic [15:0]      remainder_result_reg
);
    ////////////////////////////////////////////////////////////////////
    wire is_add = op_code == 4'(cpualu_pkg::OP_ADD);
    wire is_sub = op_code == 4'(cpualu_pkg::OP_SUB);
    wire is_and = op_code == 4'(cpualu_pkg::OP_AND);
    wire is_or  = op_code == 4'(cpualu_pkg::OP_OR);
    wire is_xor = op_code == 4'(cpualu_pkg::OP_XOR);
    wire is_shra = op_code == 4'(cpualu_pkg::OP_ARITH_RIGHT_SHIFT);
    wire is_shl  = op_code == 4'(cpualu_pkg::OP_LEFT_SHIFT);
    wire is_shrl = op_code == 4'(cpualu_pkg::OP_LOGICAL_RIGHT_SHIFT);
    wire is_mul = op_code == 4'(cpualu_pkg::OP_MUL);
    wire is_div = op_code == 4'(cpualu_pkg::OP_DIV);
    wire is_shift = is_shra | is_shl | is_shrl;
    wire div_busy;

    // Multi-bit shifts accept register operands only
    wire bad_mode = is_shift && (shift_amt != 4'h1)
                  && (src_is_mem || dst_is_mem);
    wire go = op_valid && !div_busy && !bad_mode;

    ////////////////////////////////////////////////////////////////////
    // Adder: subtract is a + ~b + 1, carry reads as not-borrow
    wire [15:0] b_eff = is_sub ? ~op_b : op_b;
    wire        cin   = is_sub ? 1'b1 : carry_in & 1'b0;
    wire [4:0]  nib   = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]}
                      + {4'h0, cin};
    wire [8:0]  sum8  = {1'b0, op_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
    wire [16:0] sum16 = {1'b0, op_a} + {1'b0, b_eff} + {16'h0000, cin};

    // Shifter: one cycle, any amount 0..15
    wire [15:0] shra_w = 16'($signed(op_a) >>> shift_amt);
    wire [7:0]  shra_b = 8'($signed(op_a[7:0]) >>> shift_amt);
    wire [15:0] shl_w  = op_a << shift_amt;
    wire [15:0] shrl_w = op_a >> shift_amt;
    wire [15:0] shrl_b = {8'h00, op_a[7:0] >> shift_amt};
    wire [15:0] shr    = is_shra ? (byte_mode ? {8'h00, shra_b} : shra_w)
                       : is_shl ? shl_w : shrl_w;
    wire [15:0] shres  = (is_shrl && byte_mode) ? shrl_b : shr;
    // Last bit shifted out goes to carry
    wire [4:0]  amt_m1  = {1'b0, shift_amt} - 5'h01;
    wire [4:0]  top_idx = byte_mode ? 5'h08 : 5'h10;
    wire [4:0]  shl_idx = top_idx - {1'b0, shift_amt};
    wire        sh_cout = (shift_amt == 4'h0) ? 1'b0
                        : is_shl ? op_a[shl_idx[3:0]]
                        : op_a[amt_m1[3:0]];

    ////////////////////////////////////////////////////////////////////
    // Multiplier: 17x17 signed core, operands extended per mode
    wire a_sx = (mul_mode == 3'(cpualu_pkg::MUL_SS))
             || (mul_mode == 3'(cpualu_pkg::MUL_SLIT));
    wire b_sx = (mul_mode == 3'(cpualu_pkg::MUL_SS))
             || (mul_mode == 3'(cpualu_pkg::MUL_US));
    wire lit  = (mul_mode == 3'(cpualu_pkg::MUL_SLIT))
             || (mul_mode == 3'(cpualu_pkg::MUL_ULIT));
    wire mbb  = mul_mode == 3'(cpualu_pkg::MUL_BB);
    wire [16:0] ma = mbb ? {9'h000, op_a[7:0]}
                   : {a_sx & op_a[15], op_a};
    wire [16:0] mb = mbb ? {9'h000, op_b[7:0]}
                   : lit ? {12'h000, literal}
                   : {b_sx & op_b[15], op_b};
    wire signed [33:0] prod = $signed(ma) * $signed(mb);

    ////////////////////////////////////////////////////////////////////
    // Result mux, byte or word width
    wire [15:0] logic_r = is_and ? (op_a & op_b)
                        : is_or ? (op_a | op_b) : (op_a ^ op_b);
    wire [15:0] arith_r = is_shift ? shres
                        : (is_add | is_sub) ? sum16[15:0] : logic_r;
    wire [15:0] narrow  = byte_mode ? {8'h00, arith_r[7:0]}
                        : arith_r;
    wire        msb     = byte_mode ? narrow[7] : narrow[15];
    wire        zero    = narrow == 16'h0000;
    wire        carry   = is_shift ? sh_cout
                        : byte_mode ? sum8[8] : sum16[16];
    wire        sa = byte_mode ? op_a[7] : op_a[15];
    wire        sb = byte_mode ? b_eff[7] : b_eff[15];
    wire        ovf = (is_add | is_sub) & (sa == sb) & (msb != sa);
    wire        upd_arith = is_add | is_sub;
    wire        upd_nz = upd_arith | is_shift | is_and | is_or | is_xor;

    ////////////////////////////////////////////////////////////////////
    wire [15:0] q_w;
    wire [15:0] r_w;
    wire        div_done;
    cpualu_div #(.STEPS(cpualu_pkg::DIV_STEPS)) cpualu_div_i (
        .clk      (clk),
        .rst      (rst),
        .start    (go && is_div),
        .is_signed(div_signed),
        .is_long  (div_long),
        .dividend ({op_a_hi, op_a}),
        .divisor  (op_b),
        .busy     (div_busy),
        .done     (div_done),
        .quot     (q_w),
        .rem      (r_w)
    );

    ////////////////////////////////////////////////////////////////////
    logic [4:0]  flags_q;
    logic [31:0] res_q;
    logic        rv_q, rm_q, rf_q, dm_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flags_q <= cpualu_pkg::FLAGS_RESET;
            res_q <= 32'h00000000;
            rv_q <= 1'b0; rm_q <= 1'b0; rf_q <= 1'b0; dm_q <= 1'b0;
        end
        else
        begin
            rf_q <= op_valid && bad_mode;
            rv_q <= (go && !is_div && op_code != 4'(cpualu_pkg::OP_NOP))
                    || div_done;
            if (go && is_div)
                dm_q <= dst_is_mem;
            if (div_done)
            begin
                res_q <= {r_w, q_w};
                rm_q  <= dm_q;
            end
            else if (go && !is_div)
            begin
                res_q <= is_mul ? prod[31:0] : {16'h0000, narrow};
                rm_q  <= dst_is_mem;
                if (upd_nz)
                begin
                    flags_q[cpualu_pkg::FLG_ZERO] <= zero;
                    flags_q[cpualu_pkg::FLG_NEG]  <= msb;
                end
                if (upd_arith | is_shift)
                    flags_q[cpualu_pkg::FLG_CARRY] <= carry;
                if (upd_arith)
                begin
                    flags_q[cpualu_pkg::FLG_OVF]   <= ovf;
                    flags_q[cpualu_pkg::FLG_DIGIT] <= nib[4];
                end
            end
        end
    end

    assign res_valid  = rv_q;
    assign res_data   = res_q;
    assign res_to_mem = rm_q;
    assign busy       = div_busy;
    assign op_refused = rf_q;
    assign status_flags = flags_q;
    assign quotient_result_reg  = q_w;
    assign remainder_result_reg = r_w;

    ////////////////////////////////////////////////////////////////////
    chk_sub_borrow: assert property (@(posedge clk) disable iff (rst)
        go && is_sub && !byte_mode |=>
        status_flags[0] == ($past(op_a) >= $past(op_b)))
        else $error("subtract carry is not not-borrow");
    chk_zero_flag: assert property (@(posedge clk) disable iff (rst)
        go && upd_nz |=> status_flags[1] == (res_data[15:0] == 16'h0000))
        else $error("zero flag disagrees with result");
    chk_byte_width: assert property (@(posedge clk) disable iff (rst)
        go && byte_mode && !is_mul |=> res_data[15:8] == 8'h00)
        else $error("byte result spills upper byte");
    chk_shift_left: assert property (@(posedge clk) disable iff (rst)
        go && is_shl && !byte_mode |=>
        res_data[15:0] == ($past(op_a) << $past(shift_amt)))
        else $error("left shift result wrong");
    chk_mult_uu: assert property (@(posedge clk) disable iff (rst)
        go && is_mul && mul_mode == 3'(cpualu_pkg::MUL_UU) |=>
        res_data == $past(op_a) * $past(op_b))
        else $error("unsigned product wrong");
    chk_shift_mode: assert property (@(posedge clk) disable iff (rst)
        op_valid && is_shift && shift_amt != 4'h1 && src_is_mem
        |=> op_refused && !res_valid)
        else $error("memory multi-bit shift accepted");
    chk_div_result: assert property (@(posedge clk) disable iff (rst)
        div_done |=> res_valid && res_data == {remainder_result_reg,
        quotient_result_reg})
        else $error("divide result not delivered");
    chk_add_ovf: assert property (@(posedge clk) disable iff (rst)
        go && is_add && !byte_mode && op_a == 16'h7FFF && op_b == 16'h0001
        |=> status_flags[3] && status_flags[2])
        else $error("signed overflow missed");
    cov_div: cover property (@(posedge clk) div_done);
    cov_sub: cover property (@(posedge clk) go && is_sub && byte_mode);
    cov_shra: cover property (@(posedge clk) go && is_shra && shift_amt == 4'hF);
endmodule

/* File: dv/cpualu_wreg_model.sv */
// Working register array model on the result side of the core ALU.
// Assumes register-bound results land in fixed slots: wreg_dst, or wreg0 and wreg1 for divide.
`timescale 1ns/1ps
module cpualu_wreg_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Result side of the block
    input  wire logic        res_valid,
    input  wire logic        res_to_mem,
    input  wire logic        is_div,
    input  wire logic [31:0] res_data,
    // Register view
    output logic [15:0]      wreg0,
    output logic [15:0]      wreg1,
    output logic [15:0]      wreg_dst
);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wreg0    <= 16'h0000;
            wreg1    <= 16'h0000;
            wreg_dst <= 16'h0000;
        end
        // Memory-bound results must leave the registers alone
        else if (res_valid && !res_to_mem)
        begin
            if (is_div)
            begin
                wreg0 <= res_data[15:0];
                wreg1 <= res_data[31:16];
            end
            else
                wreg_dst <= res_data[15:0];
        end
    end
endmodule

/* File: dv/cpualu_top_tb_top.sv */
// Self-checking bench for the core ALU: arithmetic, shift, mul, div.
// Assumes the register array model on the result side; one clock.
`timescale 1ns/1ps
module cpualu_top_tb_top;
    logic        clk, rst, op_valid, byte_mode, div_signed, div_long;
    logic        src_is_mem, dst_is_mem, carry_in;
    logic [3:0]  op_code, shift_amt, m_amt;
    logic [2:0]  mul_mode, m_mm;
    logic [15:0] op_a, op_b, op_a_hi, m_hi;
    logic [4:0]  literal, m_lit, status_flags;
    logic        res_valid, res_to_mem, busy, op_refused;
    logic        m_bm, m_sg, m_lg, m_mem;
    logic [31:0] res_data;
    logic [15:0] quotient_result_reg, remainder_result_reg;
    logic [15:0] wreg0, wreg1, wreg_dst;
    wire logic   is_div = (op_code == cpualu_pkg::OP_DIV);
    int          n_errors, checks_done;

    cpualu_top cpualu_top_i (.clk(clk), .rst(rst), .op_valid(op_valid),
        .op_code(op_code), .mul_mode(mul_mode), .byte_mode(byte_mode),
        .div_signed(div_signed), .div_long(div_long),
        .src_is_mem(src_is_mem), .dst_is_mem(dst_is_mem),
        .carry_in(carry_in), .op_a(op_a), .op_b(op_b), .op_a_hi(op_a_hi),
        .literal(literal), .shift_amt(shift_amt), .res_valid(res_valid),
        .res_data(res_data), .res_to_mem(res_to_mem), .busy(busy),
        .op_refused(op_refused), .status_flags(status_flags),
        .quotient_result_reg(quotient_result_reg),
        .remainder_result_reg(remainder_result_reg));
    cpualu_wreg_model cpualu_wreg_model_i (.clk(clk), .rst(rst),
        .res_valid(res_valid), .res_to_mem(res_to_mem), .is_div(is_div),
        .res_data(res_data), .wreg0(wreg0), .wreg1(wreg1),
        .wreg_dst(wreg_dst));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic cmp_val(input string nm, input logic [31:0] exp,
                           input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Latency 0 means a refusal is expected instead of a result
    task automatic go(input logic [3:0] op, input logic [15:0] a, b,
                      input int en, input logic [31:0] er);
        int          n;
        logic [15:0] q0;
        @(posedge clk);
        op_code    <= op;
        op_a       <= a;
        op_b       <= b;
        op_a_hi    <= m_hi;
        literal    <= m_lit;
        shift_amt  <= m_amt;
        mul_mode   <= m_mm;
        byte_mode  <= m_bm;
        div_signed <= m_sg;
        div_long   <= m_lg;
        src_is_mem <= m_mem;
        dst_is_mem <= m_mem;
        op_valid   <= 1'b1;
        @(posedge clk);
        op_valid   <= 1'b0;
        #1;
        q0 = quotient_result_reg;
        n  = 1;
        if (en == 0)
        begin
            cmp_val("refused", 1, op_refused);
            cmp_val("no result", 0, res_valid);
            return;
        end
        while (res_valid !== 1'b1 && n < 40)
        begin
            if (busy === 1'b1)
                cmp_val("held quot", q0, quotient_result_reg);
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 40)
        begin
            n_errors++;
            summarize();
        end
        cmp_val("latency", en, n);
        cmp_val("result", er, res_data);
        cmp_val("dest", m_mem, res_to_mem);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_arith();
        go(cpualu_pkg::OP_ADD, 16'hFFFF, 16'h0001, 1, 0);
        cmp_val("flags", 5'h13, status_flags);
        go(cpualu_pkg::OP_SUB, 16'h0000, 16'h0001, 1, 16'hFFFF);
        cmp_val("flags", 5'h04, status_flags);
        go(cpualu_pkg::OP_SUB, 16'h0010, 16'h0001, 1, 16'h000F);
        cmp_val("flags", 5'h01, status_flags);
        m_bm = 1'b1;
        go(cpualu_pkg::OP_SUB, 16'h0010, 16'h0020, 1, 16'h00F0);
        cmp_val("flags", 5'h14, status_flags);
        go(cpualu_pkg::OP_ADD, 16'h007F, 16'h0001, 1, 16'h0080);
        cmp_val("flags", 5'h1C, status_flags);
        m_bm  = 1'b0;
        m_mem = 1'b1;
        go(cpualu_pkg::OP_AND, 16'hF0F0, 16'h0F0F, 1, 0);
        cmp_val("flags", 5'h1A, status_flags);
        @(posedge clk);
        #1;
        cmp_val("reg kept", 16'h0080, wreg_dst);
        m_mem = 1'b0;
        go(cpualu_pkg::OP_OR, 16'h8000, 16'h0000, 1, 16'h8000);
        cmp_val("flags", 5'h1C, status_flags);
        go(cpualu_pkg::OP_XOR, 16'h5555, 16'h5555, 1, 0);
        cmp_val("flags", 5'h1A, status_flags);
        go(cpualu_pkg::OP_ADD, 16'h7FFF, 16'h0001, 1, 16'h8000);
        cmp_val("flags", 5'h1C, status_flags);
        $display("test arith done");
    endtask

    task automatic t_shift();
        logic [3:0] op_ar = cpualu_pkg::OP_ARITH_RIGHT_SHIFT;
        logic [3:0] op_lf = cpualu_pkg::OP_LEFT_SHIFT;
        logic [3:0] op_lr = cpualu_pkg::OP_LOGICAL_RIGHT_SHIFT;
        m_amt = 4'hF;
        go(op_ar, 16'h8000, 0, 1, 16'hFFFF);
        go(op_lf, 16'h0001, 0, 1, 16'h8000);
        go(op_lr, 16'h8000, 0, 1, 16'h0001);
        m_amt = 4'h3;
        m_bm  = 1'b1;
        go(op_ar, 16'h0090, 0, 1, 16'h00F2);
        m_bm  = 1'b0;
        m_amt = 4'h1;
        m_mem = 1'b1;
        go(op_lr, 16'h8000, 0, 1, 16'h4000);
        m_amt = 4'h3;
        go(op_ar, 16'h8000, 0, 0, 0);
        m_mem = 1'b0;
        $display("test shift done");
    endtask

    task automatic t_mul();
        logic [15:0] at[6] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
                               16'hFFFF, 16'h12FF};
        logic [15:0] bt[6] = '{16'h0002, 16'h0002, 16'h0002, 16'h0002,
                               16'hFFFF, 16'h34FF};
        logic [31:0] ex[6] = '{32'hFFFFFFFE, 32'h0001FFFE, 32'hFFFFFFE1,
                               32'h001EFFE1, 32'hFFFF0001, 32'h0000FE01};
        m_lit = 5'h1F;
        for (int i = 0; i < 6; i++)
        begin
            m_mm = 3'(i);
            go(cpualu_pkg::OP_MUL, at[i], bt[i], 1, ex[i]);
        end
        $display("test mul done");
    endtask

    task automatic t_div();
        logic [15:0] ht[4] = '{16'hFFFE, 16'h0001, 16'h1234, 16'h1234};
        logic [15:0] lt[4] = '{16'h7960, 16'h0000, 16'hFF9C, 16'hFF9C};
        logic [15:0] dt[4] = '{16'h0007, 16'h0002, 16'h0007, 16'h0007};
        logic [31:0] ex[4] = '{32'hFFFBC833, 32'h00008000, 32'hFFFEFFF2,
                               32'h00002484};
        for (int i = 0; i < 4; i++)
        begin
            m_sg = (i % 2 == 0);
            m_lg = (i < 2);
            m_hi = ht[i];
            go(cpualu_pkg::OP_DIV, lt[i], dt[i], 18, ex[i]);
            cmp_val("quot", ex[i][15:0], quotient_result_reg);
            cmp_val("rem", ex[i][31:16], remainder_result_reg);
            @(posedge clk);
            #1;
            cmp_val("wreg0", ex[i][15:0], wreg0);
            cmp_val("wreg1", ex[i][31:16], wreg1);
        end
        $display("test div done");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst, op_valid, byte_mode, div_signed, div_long} = 5'h10;
        {src_is_mem, dst_is_mem, carry_in, op_code, shift_amt} = 0;
        {mul_mode, op_a, op_b, op_a_hi, literal} = 0;
        {m_amt, m_mm, m_hi, m_lit, m_bm, m_sg, m_lg, m_mem} = 0;
        n_errors    = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        cmp_val("idle", 0, {res_valid, busy, status_flags});
        cmp_val("quot rem", 0, {quotient_result_reg, remainder_result_reg});
        t_arith();
        t_shift();
        t_mul();
        t_div();
        summarize();
    end
endmodule
